// ===== rtl/uerr_pkg.sv
// Constants shared by the USB error flag block
package uerr_pkg;
  localparam int ADDR_W = 8;
  localparam int FLAG_W = 8;
  localparam int BYTE_CNT_W = 10;
  localparam int TURN_CNT_W = 5;
  // Register byte offsets
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_INT_STAT = 8'h08;
  localparam logic [7:0] OFF_INT_MASK = 8'h0c;
  localparam logic [7:0] OFF_ADDR_LO = 8'h10;
  localparam logic [7:0] OFF_ADDR_HI = 8'h14;
  // Flag bit positions, then the host mode bit of the control register
  localparam int BIT_STUFF = 7;
  localparam int BIT_BMX = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_TURN = 4;
  localparam int BIT_FIELD = 3;
  localparam int BIT_CRC16 = 2;
  localparam int BIT_CRC5_EOF = 1;
  localparam int BIT_PID = 0;
  localparam int BIT_HOST_MODE = 0;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [31:0] ADDR_LO_RST = 32'h0000_0000;
  localparam logic [31:0] ADDR_HI_RST = 32'hffff_ffff;
  // Idle bit times allowed after an end of packet
  localparam logic [4:0] TURN_BITS = 5'h10;
endpackage : uerr_pkg

// ===== rtl/uerr_turn_timer.sv
// Bus turnaround idle timer counted in bit times
`timescale 1ns/1ps
module uerr_turn_timer (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Control
  input wire logic start,
  input wire logic stop,
  input wire logic bitTick,
  // Status
  output logic busy,
  output logic timeout
);
  logic [uerr_pkg::TURN_CNT_W-1:0] count_reg;
  logic busy_reg;
  logic timeout_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (stop || (busy_reg && bitTick && count_reg == uerr_pkg::TURN_BITS)) begin
      busy_reg <= 1'b0;
    end else if (start) begin
      busy_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (start || !busy_reg) begin
      count_reg <= '0;
    end else if (bitTick) begin
      count_reg <= count_reg + 5'h01;
    end
  end

  // Fires on the seventeenth idle bit time, i.e. strictly more than 16
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      timeout_reg <= 1'b0;
    end else begin
      timeout_reg <= busy_reg && !stop && bitTick && count_reg == uerr_pkg::TURN_BITS;
    end
  end

  assign busy = busy_reg;
  assign timeout = timeout_reg;

  turn_limit_a: assert property (@(posedge core_clk) disable iff (rst)
    timeout |-> $past(count_reg) == uerr_pkg::TURN_BITS && $past(bitTick))
    else $error("turnaround timeout before seventeen bit times");
endmodule : uerr_turn_timer

// ===== rtl/uerr_flags.sv
// USB error flag register block with APB access and interrupt
`timescale 1ns/1ps
module uerr_flags (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uerr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt
  output logic irq,
  // Received packet status
  input wire logic pktEnd,
  input wire logic pktIsData,
  input wire logic pktIsToken,
  input wire logic stuffViol,
  input wire logic crc16Bad,
  input wire logic crc5Bad,
  input wire logic [2:0] bitResidue,
  input wire logic pidValid,
  input wire logic [7:0] pidByte,
  output logic pktReject,
  // Turnaround timing
  input wire logic eopDone,
  input wire logic awaitResp,
  input wire logic respStart,
  input wire logic bitTick,
  // Descriptor and buffer addresses
  input wire logic bdtLoad,
  input wire logic [31:0] bdtAddr,
  input wire logic bufLoad,
  input wire logic [31:0] bufAddr,
  // Memory bus and buffer fill
  input wire logic memReq,
  input wire logic memGnt,
  input wire logic fifoXrun,
  input wire logic rxByte,
  input wire logic [uerr_pkg::BYTE_CNT_W-1:0] bufLen,
  // Frame timing
  input wire logic txActive,
  input wire logic rxActive,
  input wire logic sofZero
);
  logic [7:0] flags_reg;
  logic [7:0] flags_next;
  logic [7:0] intStat_reg;
  logic [7:0] intStat_next;
  logic [7:0] intMask_reg;
  logic [7:0] intMask_next;
  logic [31:0] addrLo_reg;
  logic [31:0] addrHi_reg;
  logic hostMode_reg;
  logic [31:0] rdData_reg;
  logic pktReject_reg;
  logic [uerr_pkg::BYTE_CNT_W-1:0] rxCount_reg;
  logic [7:0] evt;
  logic setupPh;
  logic accessPh;
  logic hit;
  logic wrEn;
  logic rdClrInt;
  logic [7:0] w1cMask;
  logic [7:0] rcMask;
  logic turnTimeout;
  logic turnBusy;
  logic truncate;

  // Address inside the software window
  function automatic logic addrOk(input logic [31:0] a, input logic [31:0] lo,
                                  input logic [31:0] hi);
    addrOk = (a >= lo) && (a <= hi);
  endfunction : addrOk

  // Offset maps to a register
  function automatic logic regHit(input logic [uerr_pkg::ADDR_W-1:0] a);
    case (a)
      uerr_pkg::OFF_FLAGS,
      uerr_pkg::OFF_CTRL,
      uerr_pkg::OFF_INT_STAT,
      uerr_pkg::OFF_INT_MASK,
      uerr_pkg::OFF_ADDR_LO,
      uerr_pkg::OFF_ADDR_HI: regHit = 1'b1;
      default: regHit = 1'b0;
    endcase
  endfunction : regHit

  // Packet identifier check nibble against its complement
  function automatic logic pidBad(input logic [7:0] p);
    pidBad = (p[3:0] != ~p[7:4]);
  endfunction : pidBad

  uerr_turn_timer u_turn (
    .core_clk(core_clk),
    .rst(rst),
    .start(eopDone && awaitResp),
    .stop(respStart),
    .bitTick(bitTick),
    .busy(turnBusy),
    .timeout(turnTimeout)
  );

  // APB phases; zero wait states
  assign setupPh = psel && !penable;
  assign accessPh = psel && penable;
  assign hit = regHit(paddr);
  assign pready = 1'b1;
  assign pslverr = accessPh && !hit;
  assign wrEn = accessPh && pwrite && hit;
  assign rdClrInt = accessPh && !pwrite && paddr == uerr_pkg::OFF_INT_STAT;

  // Truncation when a byte arrives with the buffer already full
  assign truncate = rxByte && (rxCount_reg >= bufLen);

  always_comb begin
    evt = 8'h00;
    evt[uerr_pkg::BIT_STUFF] = pktEnd && stuffViol;
    evt[uerr_pkg::BIT_BMX] = (bdtLoad && !addrOk(bdtAddr, addrLo_reg, addrHi_reg)) ||
                             (bufLoad && !addrOk(bufAddr, addrLo_reg, addrHi_reg));
    evt[uerr_pkg::BIT_DMA] = (fifoXrun && memReq && !memGnt) || truncate;
    evt[uerr_pkg::BIT_TURN] = turnTimeout;
    evt[uerr_pkg::BIT_FIELD] = pktEnd && pktIsData && bitResidue != 3'h0;
    evt[uerr_pkg::BIT_CRC16] = pktEnd && pktIsData && crc16Bad;
    if (hostMode_reg) begin
      evt[uerr_pkg::BIT_CRC5_EOF] = sofZero && (txActive || rxActive);
    end else begin
      evt[uerr_pkg::BIT_CRC5_EOF] = pktEnd && pktIsToken && crc5Bad;
    end
    evt[uerr_pkg::BIT_PID] = !hostMode_reg && pidValid && pidBad(pidByte);
  end

  // Set wins over a clear landing in the same cycle
  assign w1cMask = (wrEn && paddr == uerr_pkg::OFF_FLAGS) ? pwdata[7:0] : 8'h00;
  assign flags_next = (flags_reg & ~w1cMask) | evt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flags_reg <= uerr_pkg::FLAGS_RST;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // Only bits that software actually saw are cleared by the read
  assign rcMask = rdClrInt ? rdData_reg[7:0] : 8'h00;
  assign intStat_next = (intStat_reg & ~rcMask) | evt;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intStat_reg <= uerr_pkg::FLAGS_RST;
    end else begin
      intStat_reg <= intStat_next;
    end
  end

  // Mask taken at its next value so a mask write moves irq in step with status
  assign intMask_next = (wrEn && paddr == uerr_pkg::OFF_INT_MASK) ? pwdata[7:0] : intMask_reg;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat_next & intMask_next);
    end
  end

  // Software control registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intMask_reg <= uerr_pkg::MASK_RST;
      hostMode_reg <= 1'b0;
      addrLo_reg <= uerr_pkg::ADDR_LO_RST;
      addrHi_reg <= uerr_pkg::ADDR_HI_RST;
    end else if (wrEn) begin
      case (paddr)
        uerr_pkg::OFF_CTRL: hostMode_reg <= pwdata[uerr_pkg::BIT_HOST_MODE];
        uerr_pkg::OFF_INT_MASK: intMask_reg <= pwdata[7:0];
        uerr_pkg::OFF_ADDR_LO: addrLo_reg <= pwdata;
        uerr_pkg::OFF_ADDR_HI: addrHi_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // Read data captured in the setup phase so prdata comes from a flop
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdData_reg <= 32'h0000_0000;
    end else if (setupPh && !pwrite) begin
      case (paddr)
        uerr_pkg::OFF_FLAGS: rdData_reg <= {24'h00_0000, flags_reg};
        uerr_pkg::OFF_CTRL: rdData_reg <= {31'h0000_0000, hostMode_reg};
        uerr_pkg::OFF_INT_STAT: rdData_reg <= {24'h00_0000, intStat_reg};
        uerr_pkg::OFF_INT_MASK: rdData_reg <= {24'h00_0000, intMask_reg};
        uerr_pkg::OFF_ADDR_LO: rdData_reg <= addrLo_reg;
        uerr_pkg::OFF_ADDR_HI: rdData_reg <= addrHi_reg;
        default: rdData_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = rdData_reg;

  // Received byte count against the buffer size
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rxCount_reg <= '0;
    end else if (pktEnd) begin
      rxCount_reg <= '0;
    end else if (rxByte && !truncate) begin
      rxCount_reg <= rxCount_reg + 10'h001;
    end
  end

  // Rejection strobe toward the packet engine
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pktReject_reg <= 1'b0;
    end else begin
      pktReject_reg <= pktEnd && (stuffViol || (pktIsData && crc16Bad) ||
                       (pktIsToken && crc5Bad && !hostMode_reg));
    end
  end

  assign pktReject = pktReject_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  stuff_flag_a: assert property (pktEnd && stuffViol |=> flags_reg[7] && pktReject)
    else $error("stuffing error not flagged");

  bmx_flag_a: assert property (
    bufLoad && !addrOk(bufAddr, addrLo_reg, addrHi_reg) |=> flags_reg[6])
    else $error("bad buffer address not flagged");

  dma_flag_a: assert property (rxByte && rxCount_reg >= bufLen |=> flags_reg[5])
    else $error("truncation not flagged");

  turn_flag_a: assert property (turnTimeout |=> flags_reg[4])
    else $error("turnaround timeout not flagged");

  field_flag_a: assert property (
    pktEnd && pktIsData && bitResidue != 3'h0 |=> flags_reg[3])
    else $error("field size error not flagged");

  crc16_flag_a: assert property (
    pktEnd && pktIsData && crc16Bad |=> flags_reg[2] && pktReject)
    else $error("crc16 error not flagged or packet kept");

  eof_flag_a: assert property (
    hostMode_reg && sofZero && (txActive || rxActive) |=> flags_reg[1])
    else $error("end of frame error not flagged");

  flag_hold_a: assert property (
    flags_reg[7] && !(wrEn && paddr == uerr_pkg::OFF_FLAGS && pwdata[7]) |=> flags_reg[7])
    else $error("flag dropped without write one");

  flag_clear_a: assert property (
    wrEn && paddr == uerr_pkg::OFF_FLAGS && pwdata[3] && !evt[3] |=> !flags_reg[3])
    else $error("write one did not clear flag");

  upper_zero_a: assert property (
    setupPh && !pwrite && paddr == uerr_pkg::OFF_FLAGS |=> prdata[31:8] == 24'h00_0000)
    else $error("reserved flag bits read nonzero");

  pid_flag_a: assert property (
    !hostMode_reg && pidValid && pidByte[3:0] == pidByte[7:4] |=> flags_reg[0])
    else $error("packet id error not flagged");

  irq_level_a: assert property (|(intStat_reg & intMask_reg) |-> irq)
    else $error("interrupt low with unmasked status");

  bdt_flag_a: assert property (
    bdtLoad && !addrOk(bdtAddr, addrLo_reg, addrHi_reg) |=> flags_reg[6])
    else $error("bad table address not flagged");

  xrun_flag_a: assert property (fifoXrun && memReq && !memGnt |=> flags_reg[5])
    else $error("late grant overrun not flagged");

  trunc_count_a: assert property (
    truncate && !pktEnd |=> rxCount_reg == $past(rxCount_reg))
    else $error("truncated byte was counted");

  turn_stop_a: assert property (respStart |=> !turnBusy)
    else $error("turnaround timer kept running after response");

  eof_device_a: assert property (
    !hostMode_reg && !flags_reg[1] && !(pktEnd && pktIsToken && crc5Bad) |=> !flags_reg[1])
    else $error("end of frame flag set in device mode");

  zero_write_a: assert property (
    wrEn && paddr == uerr_pkg::OFF_FLAGS && pwdata[7:0] == 8'h00 |=>
      (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("writing zero cleared a flag");

  crc5_flag_a: assert property (
    !hostMode_reg && pktEnd && pktIsToken && crc5Bad |=> flags_reg[1] && pktReject)
    else $error("token crc5 error not flagged or packet kept");

  host_pid_a: assert property (hostMode_reg && !flags_reg[0] |=> !flags_reg[0])
    else $error("packet id error flagged in host mode");

  reject_cause_a: assert property (pktReject |-> $past(pktEnd))
    else $error("packet rejected without an end of packet");

  stat_set_a: assert property (|evt |=> (intStat_reg & $past(evt)) == $past(evt))
    else $error("event did not reach interrupt status");

  stat_clear_a: assert property (
    rdClrInt && rdData_reg[7] && !evt[7] |=> !intStat_reg[7])
    else $error("status read did not clear the bit");

  irq_low_a: assert property (!(|(intStat_reg & intMask_reg)) |-> !irq)
    else $error("interrupt high with nothing unmasked set");

  read_flags_a: assert property (
    setupPh && !pwrite && paddr == uerr_pkg::OFF_FLAGS |=> prdata[7:0] == $past(flags_reg))
    else $error("flag read returned stale value");

  mask_write_a: assert property (
    wrEn && paddr == uerr_pkg::OFF_INT_MASK |=> intMask_reg == $past(pwdata[7:0]))
    else $error("interrupt mask write lost");

  host_write_a: assert property (
    wrEn && paddr == uerr_pkg::OFF_CTRL |=> hostMode_reg == $past(pwdata[uerr_pkg::BIT_HOST_MODE]))
    else $error("mode write lost");
endmodule : uerr_flags

// ===== test/uerr_cable_model.sv
// Cable partner model that delivers received packet status to the block
`timescale 1ns/1ps
module uerr_cable_model (
  // Clock and command
  input wire logic core_clk,
  input wire logic go,
  input wire logic [2:0] kind,
  output logic busy,
  // Packet status
  output logic pktEnd,
  output logic pktIsData,
  output logic pktIsToken,
  output logic stuffViol,
  output logic crc16Bad,
  output logic crc5Bad,
  output logic [2:0] bitResidue,
  output logic pidValid,
  output logic [7:0] pidByte,
  output logic rxByte,
  // Turnaround timing
  output logic eopDone,
  output logic awaitResp,
  output logic respStart,
  output logic bitTick
);
  // Qualifiers carry junk outside pktEnd so sampling at the wrong time shows
  task automatic junk();
    {pktIsData, pktIsToken, stuffViol, crc16Bad, crc5Bad} <= 5'h1f;
    bitResidue <= 3'h7;
    pidByte <= 8'h00;
  endtask : junk
  initial begin
    junk();
    {busy, pktEnd, pidValid, rxByte, eopDone, awaitResp, respStart, bitTick} <= 8'h00;
  end
  always @(posedge core_clk) begin
    if (go === 1'b1) begin
      busy <= 1'b1;
      pidValid <= 1'b1;
      pidByte <= (kind == 3'd5) ? 8'h55 : 8'hc3;
      @(posedge core_clk);
      pidValid <= 1'b0;
      if (kind < 3'd5) begin
        repeat (2) begin
          rxByte <= 1'b1;
          @(posedge core_clk);
          rxByte <= 1'b0;
          @(posedge core_clk);
        end
        pktEnd <= 1'b1;
        pktIsData <= (kind != 3'd4);
        pktIsToken <= (kind == 3'd4);
        stuffViol <= (kind == 3'd1);
        crc16Bad <= (kind == 3'd2);
        crc5Bad <= (kind == 3'd4);
        bitResidue <= (kind == 3'd3) ? 3'h5 : 3'h0;
        @(posedge core_clk);
        pktEnd <= 1'b0;
        junk();
      end else if (kind > 3'd5) begin
        eopDone <= 1'b1;
        awaitResp <= 1'b1;
        @(posedge core_clk);
        eopDone <= 1'b0;
        // Slow bit times, one tick every third cycle
        repeat ((kind == 3'd6) ? 17 : 16) begin
          bitTick <= 1'b1;
          @(posedge core_clk);
          bitTick <= 1'b0;
          repeat (2) @(posedge core_clk);
        end
        respStart <= (kind == 3'd7);
        @(posedge core_clk);
        respStart <= 1'b0;
        awaitResp <= 1'b0;
      end
      busy <= 1'b0;
    end
  end
endmodule : uerr_cable_model

// ===== test/uerr_flags_tb_top.sv
// Testbench for the USB error flag block
`timescale 1ns/1ps
module uerr_flags_tb_top;
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, go = 0, busy;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdat, bdtAddr = 0, bufAddr = 0;
  logic pready, pslverr, rerr, irq, bdtLoad = 0, bufLoad = 0, memReq = 0, memGnt = 0;
  logic fifoXrun = 0, txActive = 0, rxActive = 0, sofZero = 0;
  logic [9:0] bufLen = 10'h3ff;
  logic [2:0] kind = 0, bitResidue;
  logic pktEnd, pktIsData, pktIsToken, stuffViol, crc16Bad, crc5Bad, pidValid, rxByte;
  logic eopDone, awaitResp, respStart, bitTick;
  logic pktReject;
  logic [7:0] pidByte;
  int miscompares = 0, testsRun = 0, cycles = 0, rejects = 0, rej0 = 0;
  logic [2:0] rowKind [8] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd5, 3'd6, 3'd7};
  logic [31:0] rowExp [8] = '{32'h00, 32'h80, 32'h04, 32'h08, 32'h02, 32'h01, 32'h10, 32'h00};
  logic [31:0] rowRej [8] = '{32'h0, 32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h0, 32'h0};
  always #10 core_clk = ~core_clk;
  // Reject pulses counted away from the edge that launches them
  always @(negedge core_clk) begin
    if (pktReject === 1'b1) begin
      rejects++;
    end
  end
  uerr_flags DUT (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .pktEnd(pktEnd), .pktIsData(pktIsData),
    .pktIsToken(pktIsToken), .stuffViol(stuffViol), .crc16Bad(crc16Bad), .crc5Bad(crc5Bad),
    .bitResidue(bitResidue), .pidValid(pidValid), .pidByte(pidByte), .pktReject(pktReject),
    .eopDone(eopDone), .awaitResp(awaitResp), .respStart(respStart), .bitTick(bitTick),
    .bdtLoad(bdtLoad), .bdtAddr(bdtAddr), .bufLoad(bufLoad), .bufAddr(bufAddr),
    .memReq(memReq), .memGnt(memGnt), .fifoXrun(fifoXrun), .rxByte(rxByte), .bufLen(bufLen),
    .txActive(txActive), .rxActive(rxActive), .sofZero(sofZero));
  uerr_cable_model partner (.core_clk(core_clk), .go(go), .kind(kind), .busy(busy),
    .pktEnd(pktEnd), .pktIsData(pktIsData), .pktIsToken(pktIsToken), .stuffViol(stuffViol),
    .crc16Bad(crc16Bad), .crc5Bad(crc5Bad), .bitResidue(bitResidue), .pidValid(pidValid),
    .pidByte(pidByte), .rxByte(rxByte), .eopDone(eopDone), .awaitResp(awaitResp),
    .respStart(respStart), .bitTick(bitTick));
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // Run is short; the ceiling only catches a hung handshake
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Idle edge after release keeps psel from being set twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : xfer
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rdat, e);
  endtask : rd
  task automatic send(input logic [2:0] k);
    go <= 1'b1;
    kind <= k;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    while (busy) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
  endtask : send
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(uerr_pkg::OFF_FLAGS, 32'h0);
    rd(uerr_pkg::OFF_ADDR_HI, 32'hffff_ffff);
    xfer(1'b1, uerr_pkg::OFF_INT_MASK, 32'h80);
    for (int i = 0; i < 8; i++) begin
      rej0 = rejects;
      send(rowKind[i]);
      check(rejects - rej0, rowRej[i]);
      rd(uerr_pkg::OFF_FLAGS, rowExp[i]);
      xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hffff_ffff);
      rd(uerr_pkg::OFF_FLAGS, 32'h0);
    end
    rd(uerr_pkg::OFF_INT_STAT, 32'h9f);
    send(3'd1);
    check({31'h0, irq}, 32'h1);
    rd(uerr_pkg::OFF_INT_STAT, 32'h80);
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    send(3'd2);
    check({31'h0, irq}, 32'h0);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'h0);
    rd(uerr_pkg::OFF_FLAGS, 32'h84);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    rd(8'h40, 32'h0);
    check({31'h0, rerr}, 32'h1);
    xfer(1'b1, uerr_pkg::OFF_ADDR_LO, 32'h1000);
    xfer(1'b1, uerr_pkg::OFF_ADDR_HI, 32'h1fff);
    bdtLoad <= 1'b1;
    bdtAddr <= 32'h1fff;
    @(posedge core_clk);
    bdtLoad <= 1'b0;
    bufLoad <= 1'b1;
    bufAddr <= 32'h2000;
    @(posedge core_clk);
    bufLoad <= 1'b0;
    rd(uerr_pkg::OFF_FLAGS, 32'h40);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    bdtLoad <= 1'b1;
    bdtAddr <= 32'h0fff;
    @(posedge core_clk);
    bdtLoad <= 1'b0;
    rd(uerr_pkg::OFF_FLAGS, 32'h40);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    memReq <= 1'b1;
    memGnt <= 1'b1;
    fifoXrun <= 1'b1;
    @(posedge core_clk);
    memGnt <= 1'b0;
    @(posedge core_clk);
    fifoXrun <= 1'b0;
    rd(uerr_pkg::OFF_FLAGS, 32'h20);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    memReq <= 1'b0;
    bufLen <= 10'h1;
    send(3'd0);
    rd(uerr_pkg::OFF_FLAGS, 32'h20);
    bufLen <= 10'h3ff;
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    xfer(1'b1, uerr_pkg::OFF_CTRL, 32'h1);
    rxActive <= 1'b1;
    sofZero <= 1'b1;
    @(posedge core_clk);
    sofZero <= 1'b0;
    rxActive <= 1'b0;
    rd(uerr_pkg::OFF_FLAGS, 32'h02);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    txActive <= 1'b1;
    sofZero <= 1'b1;
    @(posedge core_clk);
    sofZero <= 1'b0;
    txActive <= 1'b0;
    rd(uerr_pkg::OFF_FLAGS, 32'h02);
    xfer(1'b1, uerr_pkg::OFF_FLAGS, 32'hff);
    rej0 = rejects;
    send(3'd4);
    send(3'd5);
    check(rejects - rej0, 32'h0);
    rd(uerr_pkg::OFF_FLAGS, 32'h0);
    xfer(1'b0, uerr_pkg::OFF_INT_STAT, 32'h0);
    xfer(1'b1, uerr_pkg::OFF_INT_MASK, 32'hff);
    check({31'h0, irq}, 32'h0);
    send(3'd1);
    check({31'h0, irq}, 32'h1);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check({31'h0, irq}, 32'h0);
    rd(uerr_pkg::OFF_FLAGS, 32'h0);
    rd(uerr_pkg::OFF_CTRL, 32'h0);
    rd(uerr_pkg::OFF_ADDR_LO, 32'h0);
    finish_test();
  end
endmodule : uerr_flags_tb_top
